// >>> hdl/sesp_pkg.sv
// Purpose: Shared constants and types of the EEPROM select/protect front end
// Assumes: 32-bit Avalon-MM register word, byte addresses
// Notes:   Register offsets are byte addresses of aligned words
`default_nettype none

package sesp_pkg;

   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int MEM_BYTES = 8192;
   localparam int ADDR_W = $clog2(MEM_BYTES);
   localparam int LEN_W = 6;
   localparam int CNT_W = 16;

   // Device type code; value is arbitrary
   localparam logic [3:0] DEV_TYPE_DEF = 4'h6;

   // ----------------------------------------
   // Register map and fields
   // ----------------------------------------
   localparam int AW = 5;
   localparam logic [AW-1:0] REG_CTRL = 5'h00;
   localparam logic [AW-1:0] REG_STATUS = 5'h04;
   localparam logic [AW-1:0] REG_ADDR = 5'h08;
   localparam logic [AW-1:0] REG_DATA = 5'h0C;
   localparam logic [AW-1:0] REG_COUNT = 5'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_REFUSED_BIT = 1;
   localparam int ST_READ_BIT = 2;
   localparam int ST_SEL_LSB = 8;
   localparam int CNT_REFUSED_LSB = 16;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int PROG_CYCLES_DEF = 1000;

   // Byte phase of the link engine
   typedef enum logic [4:0] {
      PH_SEL  = 5'h01,
      PH_AHI  = 5'h02,
      PH_ALO  = 5'h04,
      PH_DATA = 5'h08,
      PH_IDLE = 5'h10
   } sesp_phase_t;

   // Saturating event counter step
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 16'h0001;
   endfunction

endpackage

`default_nettype wire

// >>> hdl/sesp_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Inputs are slow levels or pins
// Notes:   Stage one is read only by stage two
`default_nettype none

module sesp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import sesp_pkg::*;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } sesp_sync_t;

   sesp_sync_t s_r;
   sesp_sync_t s_nxt;

   // ----------------------------------------
   // Two stages
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = d;
      s_nxt.stab = s_r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.stab;

endmodule

`default_nettype wire

// >>> hdl/sesp_prog_timer.sv
// Purpose: Internal programming cycle timer
// Assumes: start is a one-cycle pulse on ref_clk
// Notes:   busy comes straight from a flop
`default_nettype none

module sesp_prog_timer #(
   parameter int CYCLES = sesp_pkg::PROG_CYCLES_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   output logic busy
);
   import sesp_pkg::*;

   typedef struct packed {
      logic busy;
      logic [31:0] left;
   } sesp_tmr_t;

   sesp_tmr_t t_r;
   sesp_tmr_t t_nxt;

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   always_comb begin
      t_nxt = t_r;
      if (start && !t_r.busy) begin
         t_nxt.busy = 1'b1;
         t_nxt.left = 32'(CYCLES - 1);
      end else if (t_r.busy) begin
         if (t_r.left == 32'h0) begin
            t_nxt.busy = 1'b0;
         end else begin
            t_nxt.left = t_r.left - 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         t_r <= '0;
      end else if (ce) begin
         t_r <= t_nxt;
      end
   end

   assign busy = t_r.busy;

endmodule

`default_nettype wire

// >>> hdl/sesp_top.sv
// Purpose: Two-wire EEPROM slave front end: select match, open-drain
//          data drive, write protect, register view over Avalon-MM
// Assumes: scl is made by the bus master and may stop between frames
// Notes:   Byte engine runs on scl, frame control on ref_clk
//
// Behaviour
// RULE1: Array holds 8192 bytes; each access addresses one 13-bit location.
// RULE2: Bits are shifted in and driven out timed by the master's scl.
// RULE3: Data line is open drain: only pulled low or released.
// RULE4: Select bits b3..b1 must equal the three straps to respond.
// RULE5: Unconnected strap inputs count as logic 0. The code adds no pull; straps are compared as synchronised.
// RULE6: With write protect high no array byte can be written.
// RULE7: Write protect low or floating permits writes.
// RULE8: Under write protect, select and address acked, data bytes not.
// RULE9: Upper four select bits must match the device type code.
// RULE10: Last select bit is direction: 1 read, 0 write.
// RULE11: Match acks in ninth bit time; mismatch releases bus to standby.
// RULE12: Stop after a write starts the internal write cycle.
// RULE13: Refused data bytes mean no programming cycle at the stop.
`default_nettype none

module sesp_top #(
   parameter int PROG_CYCLES = sesp_pkg::PROG_CYCLES_DEF,
   parameter logic [3:0] DEV_TYPE = sesp_pkg::DEV_TYPE_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic strap_select_bit_high,
   input wire logic strap_select_bit_mid,
   input wire logic strap_select_bit_low,
   input wire logic write_protect_input,
   input wire logic [sesp_pkg::AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic prog_start,
   output logic [sesp_pkg::ADDR_W-1:0] prog_addr,
   output logic [sesp_pkg::LEN_W-1:0] prog_len,
   output logic prog_busy
);
   import sesp_pkg::*;

   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef struct packed {
      sesp_phase_t ph;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic ack_want;
      logic sel_ok;
      logic [7:0] sel;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic [LEN_W-1:0] len;
      logic refused;
   } sesp_link_t;

   typedef struct packed {
      logic scl_d;
      logic sda_d;
      logic armed;
      logic link_clr;
      logic wait_n;
      logic [31:0] rdata;
      logic ctrl_en;
      logic [7:0] last_sel;
      logic last_refused;
      logic last_read;
      logic [ADDR_W-1:0] last_addr;
      logic [7:0] last_data;
      logic [CNT_W-1:0] commit_cnt;
      logic [CNT_W-1:0] refuse_cnt;
      logic start_p;
      logic [ADDR_W-1:0] p_addr;
      logic [LEN_W-1:0] p_len;
      logic sda_o;
   } sesp_core_t;

   localparam sesp_link_t LINK_RST = '{ph: PH_SEL, default: '0};

   sesp_link_t lk_r;
   sesp_link_t lk_nxt;
   logic oe_r;
   logic oe_nxt;
   sesp_core_t c_r;
   sesp_core_t c_nxt;

   logic [1:0] pin_s;
   logic scl_s;
   logic sda_s;
   logic [4:0] lk_in_s;
   logic [2:0] strap_s;
   logic wp_s;
   logic en_s;
   logic busy;
   logic start_cond;
   logic stop_cond;
   logic commit;
   logic [7:0] byte_in;

   // ----------------------------------------
   // Crossings
   // ----------------------------------------
   // Bus pins into the ref_clk domain for start/stop watching
   sesp_sync #(.W(2)) u_pin_sync (
      .clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .d({scl, sda_i}),
      .q(pin_s)
   );
   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   // Straps, protect pin and enable into the scl domain; the select
   // compare happens eight edges into a frame, so two edges of lag are free
   sesp_sync #(.W(5)) u_link_sync (
      .clk(scl),
      .rst(1'b0),
      .ce(1'b1),
      .d({strap_select_bit_high, strap_select_bit_mid, strap_select_bit_low,
          write_protect_input, c_r.ctrl_en}),
      .q(lk_in_s)
   );
   assign strap_s = lk_in_s[4:2];
   assign wp_s = lk_in_s[1];
   assign en_s = lk_in_s[0];

   sesp_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .start(c_r.start_p),
      .busy(busy)
   );

   // ----------------------------------------
   // Link byte engine (scl domain)
   // ----------------------------------------
   // RULE2: shift on scl rise
   assign byte_in = {lk_r.shreg[6:0], sda_i};

   always_comb begin
      lk_nxt = lk_r;
      if (lk_r.bitcnt == 4'h8) begin
         // Ninth clock: acknowledge slot closes
         lk_nxt.bitcnt = 4'h0;
         lk_nxt.ack_want = 1'b0;
      end else begin
         lk_nxt.shreg = byte_in;
         lk_nxt.bitcnt = lk_r.bitcnt + 4'h1;
         if (lk_r.bitcnt == 4'h7) begin
            unique case (lk_r.ph)
               PH_SEL: begin
                  lk_nxt.sel = byte_in;
                  // RULE9: type code check
                  // RULE4: strap compare
                  // RULE5: no pull to 0 is added; straps are compared as synchronised
                  if (byte_in[7:4] == DEV_TYPE && byte_in[3:1] == strap_s && en_s) begin
                     lk_nxt.ack_want = 1'b1;
                     lk_nxt.sel_ok = 1'b1;
                     // RULE10: direction bit
                     // Reads are served by the array side; the front end stops here
                     lk_nxt.ph = byte_in[0] ? PH_IDLE : PH_AHI;
                  end else begin
                     // RULE11: mismatch goes to standby
                     lk_nxt.ph = PH_IDLE;
                  end
               end
               PH_AHI: begin
                  // RULE1: upper address bits above 13 are ignored
                  // RULE8: address bytes acked even when protected
                  lk_nxt.addr[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
                  lk_nxt.ack_want = 1'b1;
                  lk_nxt.ph = PH_ALO;
               end
               PH_ALO: begin
                  lk_nxt.addr[7:0] = byte_in;
                  lk_nxt.ack_want = 1'b1;
                  lk_nxt.ph = PH_DATA;
               end
               PH_DATA: begin
                  if (wp_s) begin
                     // RULE6: protected, byte dropped
                     // RULE8: data byte not acked
                     lk_nxt.refused = 1'b1;
                  end else begin
                     // RULE7: low or floating protect accepts
                     lk_nxt.ack_want = 1'b1;
                     lk_nxt.data = byte_in;
                     if (lk_r.len != {LEN_W{1'b1}}) begin
                        lk_nxt.len = lk_r.len + 6'h01;
                     end
                  end
               end
               PH_IDLE: begin
                  lk_nxt.ack_want = 1'b0;
               end
            endcase
         end
      end
   end

   // Cleared by the frame controller at every start and stop, so no scl
   // edge outside a frame can leave stale state behind
   always_ff @(posedge scl or posedge c_r.link_clr) begin
      if (c_r.link_clr) begin
         lk_r <= LINK_RST;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   // RULE11: pull low through the ninth bit time
   // RULE2: drive changes only on scl fall
   assign oe_nxt = lk_r.ack_want && (lk_r.bitcnt == 4'h8);

   always_ff @(negedge scl or posedge c_r.link_clr) begin
      if (c_r.link_clr) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= oe_nxt;
      end
   end

   // ----------------------------------------
   // Frame control and registers (ref_clk)
   // ----------------------------------------
   assign start_cond = scl_s && c_r.scl_d && c_r.sda_d && !sda_s;
   assign stop_cond = scl_s && c_r.scl_d && !c_r.sda_d && sda_s;
   // RULE13: any refused byte cancels programming
   assign commit = (lk_r.ph == PH_DATA) && (lk_r.len != '0) && !lk_r.refused
                   && !c_r.link_clr;

   always_comb begin
      c_nxt = c_r;
      c_nxt.scl_d = scl_s;
      c_nxt.sda_d = sda_s;
      c_nxt.start_p = 1'b0;
      c_nxt.sda_o = 1'b0;

      // Avalon slave: one cycle of wait, then answer for one cycle
      if (!c_r.wait_n) begin
         c_nxt.wait_n = 1'b1;
      end else if (avs_read || avs_write) begin
         c_nxt.wait_n = 1'b0;
         c_nxt.rdata = 32'h0;
         if (avs_read) begin
            unique case (avs_address)
               REG_CTRL: c_nxt.rdata[CTRL_EN_BIT] = c_r.ctrl_en;
               REG_STATUS: begin
                  c_nxt.rdata[ST_BUSY_BIT] = busy;
                  c_nxt.rdata[ST_REFUSED_BIT] = c_r.last_refused;
                  c_nxt.rdata[ST_READ_BIT] = c_r.last_read;
                  c_nxt.rdata[ST_SEL_LSB +: 8] = c_r.last_sel;
               end
               REG_ADDR: c_nxt.rdata[ADDR_W-1:0] = c_r.last_addr;
               REG_DATA: c_nxt.rdata[7:0] = c_r.last_data;
               REG_COUNT: c_nxt.rdata = {c_r.refuse_cnt, c_r.commit_cnt};
               default: c_nxt.rdata = 32'h0;
            endcase
         end else if (avs_address == REG_CTRL && avs_byteenable[0]) begin
            c_nxt.ctrl_en = avs_writedata[CTRL_EN_BIT];
         end else if (avs_address == REG_COUNT && avs_byteenable != 4'h0) begin
            c_nxt.commit_cnt = '0;
            c_nxt.refuse_cnt = '0;
         end
      end

      // Release the engine once scl is low after an accepted start
      if (c_r.armed && !scl_s) begin
         c_nxt.armed = 1'b0;
         c_nxt.link_clr = 1'b0;
      end

      // A start during programming is ignored: no acks until done
      if (start_cond) begin
         c_nxt.link_clr = 1'b1;
         c_nxt.armed = !busy;
      end

      // Engine words are quiet since the last scl rise, long before
      // the synchronised stop is seen, so they are sampled here
      if (stop_cond) begin
         c_nxt.link_clr = 1'b1;
         c_nxt.armed = 1'b0;
         if (!c_r.link_clr && lk_r.sel_ok) begin
            c_nxt.last_sel = lk_r.sel;
            c_nxt.last_read = lk_r.sel[0];
            c_nxt.last_refused = lk_r.refused;
         end
         if (!c_r.link_clr && lk_r.refused) begin
            c_nxt.refuse_cnt = sat_inc(c_nxt.refuse_cnt);
         end
         // RULE12: stop launches the write cycle
         if (commit) begin
            c_nxt.start_p = 1'b1;
            c_nxt.p_addr = lk_r.addr;
            c_nxt.p_len = lk_r.len;
            c_nxt.last_addr = lk_r.addr;
            c_nxt.last_data = lk_r.data;
            c_nxt.commit_cnt = sat_inc(c_nxt.commit_cnt);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         c_r <= '{wait_n: 1'b1, link_clr: 1'b1, ctrl_en: CTRL_EN_RST,
                  scl_d: 1'b1, sda_d: 1'b1, default: '0};
      end else if (ce) begin
         c_r <= c_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // RULE3: line only pulled low, never driven high
   assign sda_o = c_r.sda_o;
   assign sda_oe = oe_r;
   assign avs_readdata = c_r.rdata;
   assign avs_waitrequest = c_r.wait_n;
   assign prog_start = c_r.start_p;
   assign prog_addr = c_r.p_addr;
   assign prog_len = c_r.p_len;
   assign prog_busy = busy;

endmodule

`default_nettype wire

// >>> sim/sesp_top_asserts.sv
// Purpose: Port-level checks of the select/protect front end
// Assumes: Bound into sesp_top; ack checks run on scl
// Notes:   Bus and write-cycle checks run on ref_clk
`default_nettype none
module sesp_top_asserts #(
   parameter int PROG_CYCLES = sesp_pkg::PROG_CYCLES_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic prog_start,
   input wire logic [sesp_pkg::ADDR_W-1:0] prog_addr,
   input wire logic [sesp_pkg::LEN_W-1:0] prog_len,
   input wire logic prog_busy
);
   import sesp_pkg::*;
   // ----------------------------------------
   // Busy length counter
   // ----------------------------------------
   // Holds while ce is low, since the timer freezes then too
   logic [15:0] busy_cnt_r;
   logic [15:0] busy_cnt_nxt;
   always_comb begin
      busy_cnt_nxt = prog_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
      if (!ce) busy_cnt_nxt = busy_cnt_r;
   end
   always_ff @(posedge ref_clk) begin
      if (rst) busy_cnt_r <= 16'h0000;
      else busy_cnt_r <= busy_cnt_nxt;
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_wait_answer: assert property (@(posedge ref_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
      else $error("bus request not answered next cycle");
   a_wait_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      !avs_waitrequest && ce |=> avs_waitrequest) else $error("answer longer than one cycle");
   a_wait_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
   a_sda_pull_only: assert property (@(posedge ref_clk) disable iff (rst)
      !sda_o) else $error("data line driven high");
   a_start_busy: assert property (@(posedge ref_clk) disable iff (rst)
      prog_start && ce |=> prog_busy && !prog_start) else $error("write cycle start bad");
   a_commit_len: assert property (@(posedge ref_clk) disable iff (rst)
      prog_start |-> prog_len != '0) else $error("write cycle with no bytes");
   a_busy_length: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(prog_busy) |-> busy_cnt_r == PROG_CYCLES) else $error("busy length wrong");
   a_prog_hold: assert property (@(posedge ref_clk) disable iff (rst)
      prog_busy |-> $stable(prog_addr) && $stable(prog_len)) else $error("prog moved");
   a_ack_gap: assert property (@(posedge scl) disable iff (rst)
      sda_oe |=> !sda_oe [*8]) else $error("ack not in ninth bit time");
endmodule
bind sesp_top sesp_top_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.ref_clk(ref_clk),
   .rst(rst), .ce(ce), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .prog_start(prog_start),
   .prog_addr(prog_addr), .prog_len(prog_len), .prog_busy(prog_busy));
`default_nettype wire

// >>> sim/sesp_bfm_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Pull-up on the data line, resolved by the bench
// Notes:   scl stands high between frames; bit period 12 ns
`default_nettype none
module sesp_bfm_master (
   output logic scl,
   output logic sda_m,
   input wire logic sda_w
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Frame tasks
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Long start hold, the device sees start through a synchroniser
   task automatic start_cond();
      sda_m = 1'b1;
      #6 scl = 1'b1;
      #24 sda_m = 1'b0;
      #24 scl = 1'b0;
      #12;
   endtask
   task automatic stop_cond();
      sda_m = 1'b0;
      #6 scl = 1'b1;
      #24 sda_m = 1'b1;
      #24;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_m = b[i];
         #3 scl = 1'b1;
         #6 scl = 1'b0;
         #3;
      end
      sda_m = 1'b1;
      #3 scl = 1'b1;
      // An unknown line level stays unknown so the compare catches it
      ack = ~sda_w;
      #6 scl = 1'b0;
      #3;
   endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the select/protect front end
// Assumes: Write cycle length cut to 20 clocks
// Notes:   Registers over Avalon-MM, frames from the bus master model
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import sesp_pkg::*;
   localparam int PC = 20;
   logic ref_clk = 1'b0;
   logic rst, ce, scl, sda_m, sda_w, sda_o, sda_oe, wp;
   logic [2:0] strap;
   logic [4:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, prog_start, prog_busy;
   logic [31:0] avs_writedata, avs_readdata;
   logic [ADDR_W-1:0] prog_addr, seen_addr;
   logic [LEN_W-1:0] prog_len, seen_len;
   int n_errors = 0, total_checks = 0, cycles = 0, starts = 0;
   always #2 ref_clk = ~ref_clk;
   // Pull-up wins unless someone pulls low
   assign sda_w = (sda_oe && !sda_o) ? 1'b0 : sda_m;
   sesp_top #(.PROG_CYCLES(PC)) dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .scl(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .strap_select_bit_high(strap[2]),
      .strap_select_bit_mid(strap[1]), .strap_select_bit_low(strap[0]),
      .write_protect_input(wp), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .prog_start(prog_start), .prog_addr(prog_addr), .prog_len(prog_len),
      .prog_busy(prog_busy));
   sesp_bfm_master m_u (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // No cycle count assumed; the cycle ceiling below ends a hang
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic xfer(input logic [7:0] b, input logic exp, input string what);
      logic ack;
      m_u.send_byte(b, ack);
      chk(what, {31'h0, exp}, {31'h0, ack});
   endtask
   // Waits out one full write cycle, then checks the start count
   task automatic commit(input int n, input logic [12:0] a, input logic [5:0] len);
      repeat (PC + 8) @(posedge ref_clk);
      chk("starts", n, starts);
      chk("prog_addr", {19'h0, a}, {19'h0, seen_addr});
      chk("prog_len", {26'h0, len}, {26'h0, seen_len});
      chk("prog_busy", 32'h0, {31'h0, prog_busy});
   endtask
   // Captures write-cycle starts and cuts a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (prog_start === 1'b1) begin
         starts++;
         seen_addr = prog_addr;
         seen_len = prog_len;
      end
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [2:0] bad;
      rst = 1'b1;
      ce = 1'b1;
      strap = 3'b000;
      wp = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rd(REG_CTRL, 32'h1, "ctrl reset");
      rd(REG_STATUS, 32'h0, "status reset");
      rd(REG_COUNT, 32'h0, "count reset");
      rd(5'h14, 32'h0, "unmapped read");
      $display("test reset done");
      for (int s = 0; s < 8; s++) begin
         bad = s[2:0] ^ (3'b001 << (s % 3));
         @(posedge ref_clk);
         strap <= s[2:0];
         m_u.start_cond();
         xfer({DEV_TYPE_DEF, s[2:0], 1'b0}, 1'b1, "select match");
         m_u.stop_cond();
         m_u.start_cond();
         xfer({DEV_TYPE_DEF, bad, 1'b0}, 1'b0, "strap mismatch");
         m_u.stop_cond();
         m_u.start_cond();
         xfer({~DEV_TYPE_DEF, s[2:0], 1'b0}, 1'b0, "type mismatch");
         m_u.stop_cond();
      end
      $display("test select done");
      @(posedge ref_clk);
      strap <= 3'b101;
      m_u.start_cond();
      xfer({DEV_TYPE_DEF, 4'hA}, 1'b1, "write select");
      xfer(8'hFA, 1'b1, "addr high");
      xfer(8'hBC, 1'b1, "addr low");
      xfer(8'h55, 1'b1, "data 0");
      xfer(8'hA7, 1'b1, "data 1");
      m_u.stop_cond();
      // Clock enable low must freeze the write-cycle timer mid-count
      @(posedge ref_clk);
      ce <= 1'b0;
      repeat (PC + 8) @(posedge ref_clk);
      chk("busy frozen", 32'h1, {31'h0, prog_busy});
      ce <= 1'b1;
      commit(1, 13'h1ABC, 6'h02);
      rd(REG_ADDR, 32'h1ABC, "addr reg");
      rd(REG_DATA, 32'hA7, "data reg");
      rd(REG_COUNT, 32'h1, "count write");
      $display("test write done");
      @(posedge ref_clk);
      wp <= 1'b1;
      m_u.start_cond();
      xfer({DEV_TYPE_DEF, 4'hA}, 1'b1, "wp select");
      xfer(8'h03, 1'b1, "wp addr high");
      xfer(8'h21, 1'b1, "wp addr low");
      xfer(8'h3C, 1'b0, "wp data 0");
      xfer(8'hC3, 1'b0, "wp data 1");
      m_u.stop_cond();
      commit(1, 13'h1ABC, 6'h02);
      rd(REG_STATUS, {16'h0, DEV_TYPE_DEF, 4'hA, 8'h02}, "status wp");
      rd(REG_DATA, 32'hA7, "data kept");
      rd(REG_COUNT, 32'h00010001, "count wp");
      $display("test protect done");
      @(posedge ref_clk);
      wp <= 1'b0;
      m_u.start_cond();
      xfer({DEV_TYPE_DEF, 4'hB}, 1'b1, "read select");
      m_u.stop_cond();
      rd(REG_STATUS, {16'h0, DEV_TYPE_DEF, 4'hB, 8'h04}, "status read");
      wr(REG_CTRL, 32'h0);
      m_u.start_cond();
      xfer({DEV_TYPE_DEF, 4'hA}, 1'b0, "disabled select");
      m_u.stop_cond();
      wr(REG_CTRL, 32'h1);
      wr(REG_COUNT, 32'h0);
      rd(REG_COUNT, 32'h0, "count clear");
      $display("test misc done");
      stop_test();
   end
endmodule
`default_nettype wire
